// File: dv/ledwp_bench.sv
// self-checking bench: host model writes, a reference model predicts outputs
`timescale 1ns/1ns
module ledwp_bench
   import ledwp_pkg::*;
;
   logic clk, rstn, modeSel, writeStrobe, decimalPointOut, hexOrBcdSelect, noDecode;
   logic powerOn, bankSelA, oscHalt, displayBlank, seqActive, seqOn;
   logic [7:0] busLine, scanData, ctrlRef, lf;
   logic [2:0] scanDigit, digitAddr, addrRef;
   logic [7:0] memRef [16];
   int seqIdx, n_errors, compares, cyc;
   ledwp_host host_u (.clk(clk), .busLine(busLine), .modeSel(modeSel), .writeStrobe(writeStrobe));
   ledwp_top dut_u (.clk(clk), .rstn(rstn), .busLine(busLine), .modeSel(modeSel),
      .writeStrobe(writeStrobe), .scanDigit(scanDigit), .scanData(scanData),
      .decimalPointOut(decimalPointOut), .hexOrBcdSelect(hexOrBcdSelect), .noDecode(noDecode),
      .powerOn(powerOn), .bankSelA(bankSelA), .oscHalt(oscHalt), .displayBlank(displayBlank),
      .seqActive(seqActive), .digitAddr(digitAddr));
   // clock and a hang limit well above the expected run
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_errors++;
         results();
      end
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // no-decode forces bank a, otherwise the bank bit decides
   function automatic logic bankOf();
      return ctrlRef[5] | ctrlRef[3];
   endfunction : bankOf
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chkCtrl();
      chk("hexsel", ctrlRef[6], hexOrBcdSelect);
      chk("nodecode", ctrlRef[5], noDecode);
      chk("power", {ctrlRef[4], ~ctrlRef[4], ~ctrlRef[4]}, {powerOn, oscHalt, displayBlank});
      chk("banka", bankOf(), bankSelA);
      chk("seq", seqOn, seqActive);
      chk("addr", addrRef, digitAddr);
   endtask : chkCtrl
   // one write through the host, then the model follows and control outputs are compared
   task automatic wr(input logic mode, input logic [7:0] d);
      host_u.put(mode, d);
      if (mode)
      begin
         ctrlRef = d;
         seqOn = d[7];
         seqIdx = 0;
         if (!d[7]) addrRef = d[2:0];
      end
      else
      begin
         memRef[{bankOf(), seqOn ? seqIdx[2:0] : addrRef}] = d;
         if (seqOn) seqIdx++;
         if (seqIdx == 8) seqOn = 1'b0;
      end
      chkCtrl();
   endtask : wr
   task automatic seqFill(input logic [7:0] c);
      wr(1'b1, c);
      for (int i = 0; i < 8; i++)
      begin
         lf = lfsr(lf);
         wr(1'b0, lf);
      end
   endtask : seqFill
   // scan every digit of the current bank; blank while shut down
   task automatic readAll();
      logic [7:0] e;
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         scanDigit = i[2:0];
         repeat (3) @(negedge clk);
         e = ctrlRef[4] ? memRef[{bankOf(), i[2:0]}] : 8'h00;
         chk("scan", e, scanData);
         chk("dp", e[7], decimalPointOut);
      end
   endtask : readAll
   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   // main sequence: reset, sequential fills, single digits, random control words
   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      scanDigit = 3'h0;
      ctrlRef = LEDWP_CTRL_RESET;
      seqOn = 1'b0;
      addrRef = 3'h0;
      lf = 8'h10;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      chkCtrl();
      chk("scan", 8'h00, scanData);
      $display("test reset done");
      seqFill(8'h90);
      seqFill(8'hB0);
      seqFill(8'h98);
      readAll();
      wr(1'b1, 8'h10);
      readAll();
      $display("test sequential done");
      for (int a = 0; a < 8; a++)
      begin
         wr(1'b1, 8'h18 | a[7:0]);
         lf = lfsr(lf);
         wr(1'b0, lf);
         wr(1'b0, ~lf);
      end
      readAll();
      $display("test single digit done");
      for (int k = 0; k < 12; k++)
      begin
         lf = lfsr(lf);
         // update-type kept low: an announced fill must be followed by eight writes
         wr(1'b1, lf & 8'h7F);
         readAll();
      end
      $display("test random control done");
      // reset mid-run: control state returns to its reset value, memory is kept
      @(negedge clk);
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      ctrlRef = LEDWP_CTRL_RESET;
      seqOn = 1'b0;
      seqIdx = 0;
      addrRef = 3'h0;
      repeat (4) @(negedge clk);
      chkCtrl();
      chk("scan", 8'h00, scanData);
      wr(1'b1, 8'h18);
      readAll();
      $display("test mid-run reset done");
      results();
   end
endmodule : ledwp_bench

// File: dv/ledwp_host.sv
// host model that writes control words and display bytes through the pins
`timescale 1ns/1ns
module ledwp_host
   import ledwp_pkg::*;
(
   // clock
   input wire logic clk,
   // host pins
   output logic [LEDWP_DATA_W-1:0] busLine,
   output logic modeSel,
   output logic writeStrobe
);
   // one write: setup, strobe high, strobe low, then the bus is let go
   task automatic put(input logic mode, input logic [7:0] data);
      @(negedge clk);
      modeSel = mode;
      busLine = data;
      repeat (5) @(negedge clk);
      writeStrobe = 1'b1;
      repeat (5) @(negedge clk);
      writeStrobe = 1'b0;
      repeat (5) @(negedge clk);
      busLine = ~data; // a let-go bus must not keep the old byte
   endtask : put
   // pins idle low from time zero so the first rise is clean
   initial
   begin
      busLine = 8'h00;
      modeSel = 1'b0;
      writeStrobe = 1'b0;
   end
endmodule : ledwp_host

// File: rtl/ledwp_pkg.sv
// shared constants for the led display write port
package ledwp_pkg;
   // sizes
   localparam int LEDWP_DATA_W = 8;
   localparam int LEDWP_DIGITS = 8;
   localparam int LEDWP_IDX_W = 3;
   localparam int LEDWP_ADDR_W = 4;
   // control word field positions (bus line numbers)
   localparam int LEDWP_UPDATE_TYPE_BIT = 7;
   localparam int LEDWP_CODE_SEL_BIT = 6;
   localparam int LEDWP_DECODE_EN_BIT = 5;
   localparam int LEDWP_POWER_BIT = 4;
   localparam int LEDWP_BANK_SEL_BIT = 3;
   localparam int LEDWP_ADDR_MSB = 2;
   localparam int LEDWP_ADDR_LSB = 0;
   // display data: most significant line is the decimal point
   localparam int LEDWP_DP_BIT = 7;
   // control word reset value: shut down, decoded, code b, bank b
   localparam logic [7:0] LEDWP_CTRL_RESET = 8'h00;
   localparam logic [2:0] LEDWP_LAST_DIGIT = 3'h7;
   // bank select encodings as written into the memory address
   localparam logic LEDWP_BANK_A = 1'b1;
endpackage : ledwp_pkg

// File: rtl/ledwp_ram.sv
// two-bank display memory, eight digit words per bank, registered read
`timescale 1ns/1ns
module ledwp_ram
   import ledwp_pkg::*;
(
   // clock
   input wire logic clk,
   // write side
   input wire logic wrEn,
   input wire logic [LEDWP_ADDR_W-1:0] wrAddr,
   input wire logic [LEDWP_DATA_W-1:0] wrData,
   // read side
   input wire logic [LEDWP_ADDR_W-1:0] rdAddr,
   output logic [LEDWP_DATA_W-1:0] rdData
);
   logic [LEDWP_DATA_W-1:0] mem [0:2*LEDWP_DIGITS-1];

   // no reset on the array: contents are undefined until software writes them
   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : ledwp_ram

// File: rtl/ledwp_top.sv
// write port and control word decode of an eight digit led display driver
`timescale 1ns/1ns
module ledwp_top
   import ledwp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // host pins, asynchronous to clk
   input wire logic [LEDWP_DATA_W-1:0] busLine,
   input wire logic modeSel,
   input wire logic writeStrobe,
   // scan side read of the display memory
   input wire logic [LEDWP_IDX_W-1:0] scanDigit,
   output logic [LEDWP_DATA_W-1:0] scanData,
   output logic decimalPointOut,
   // decoded control state
   output logic hexOrBcdSelect,
   output logic noDecode,
   output logic powerOn,
   output logic bankSelA,
   output logic oscHalt,
   output logic displayBlank,
   output logic seqActive,
   output logic [LEDWP_IDX_W-1:0] digitAddr
);
   // three-stage strobe synchroniser, four-stage mode and bus; stage 1 feeds only stage 2
   logic strobeS1_reg, strobeS2_reg, strobeS3_reg, strobeLvl_reg;
   logic modeS1_reg, modeS2_reg, modeS3_reg, modeS4_reg;
   logic [LEDWP_DATA_W-1:0] dataS1_reg, dataS2_reg, dataS3_reg, dataS4_reg;
   logic [LEDWP_DATA_W-1:0] ctrl_reg;
   logic seqActive_reg, seqActive_next;
   logic [LEDWP_IDX_W-1:0] seqIndex_reg, seqIndex_next;
   logic [LEDWP_IDX_W-1:0] digitAddr_reg;
   logic [LEDWP_DATA_W-1:0] scanData_reg;

   // edge and write classification
   wire strobeAgree = (strobeS2_reg == strobeS3_reg);
   wire wrPulse = strobeAgree && strobeS3_reg && !strobeLvl_reg;
   wire ctrlWrite = wrPulse && modeS4_reg;
   wire ramWrite = wrPulse && !modeS4_reg;
   wire [LEDWP_DATA_W-1:0] wrData = dataS4_reg;

   // decode of the stored control word
   wire ctrlSeq = ctrl_reg[LEDWP_UPDATE_TYPE_BIT];
   wire ctrlHex = ctrl_reg[LEDWP_CODE_SEL_BIT];
   wire ctrlNoDec = ctrl_reg[LEDWP_DECODE_EN_BIT];
   wire ctrlPower = ctrl_reg[LEDWP_POWER_BIT];
   wire ctrlBank = ctrl_reg[LEDWP_BANK_SEL_BIT];
   // no-decode mode ignores the bank bit and always uses bank a
   wire effBank = ctrlNoDec ? LEDWP_BANK_A : ctrlBank;
   wire [LEDWP_IDX_W-1:0] wrIndex = seqActive_reg ? seqIndex_reg : digitAddr_reg;
   wire [LEDWP_ADDR_W-1:0] ramWrAddr = {effBank, wrIndex};
   wire [LEDWP_ADDR_W-1:0] ramRdAddr = {effBank, scanDigit};
   wire [LEDWP_DATA_W-1:0] ramRdData;

   // synchronise strobe, mode and bus; data is one stage older than the strobe
   // so the captured byte was sampled while the strobe was still low (zero hold)
   always_ff @(posedge clk)
   begin
      strobeS1_reg <= writeStrobe;
      strobeS2_reg <= strobeS1_reg;
      strobeS3_reg <= strobeS2_reg;
      modeS1_reg <= modeSel;
      modeS2_reg <= modeS1_reg;
      modeS3_reg <= modeS2_reg;
      modeS4_reg <= modeS3_reg;
      dataS1_reg <= busLine;
      dataS2_reg <= dataS1_reg;
      dataS3_reg <= dataS2_reg;
      dataS4_reg <= dataS3_reg;
   end

   // filtered strobe level: a change counts once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         strobeLvl_reg <= 1'b0;
      end
      else if (strobeAgree)
      begin
         strobeLvl_reg <= strobeS3_reg;
      end
   end

   // control word register, loaded only by mode-high writes
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl_reg <= LEDWP_CTRL_RESET;
      end
      else if (ctrlWrite)
      begin
         ctrl_reg <= wrData;
      end
   end

   // sequential fill pointer and single digit address
   always_comb
   begin
      seqActive_next = seqActive_reg;
      seqIndex_next = seqIndex_reg;
      if (ctrlWrite)
      begin
         seqActive_next = wrData[LEDWP_UPDATE_TYPE_BIT];
         seqIndex_next = '0;
      end
      else if (ramWrite && seqActive_reg)
      begin
         seqIndex_next = seqIndex_reg + 3'h1;
         if (seqIndex_reg == LEDWP_LAST_DIGIT)
         begin
            seqActive_next = 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         seqActive_reg <= 1'b0;
         seqIndex_reg <= '0;
         digitAddr_reg <= '0;
      end
      else
      begin
         seqActive_reg <= seqActive_next;
         seqIndex_reg <= seqIndex_next;
         if (ctrlWrite && !wrData[LEDWP_UPDATE_TYPE_BIT])
         begin
            digitAddr_reg <= wrData[LEDWP_ADDR_MSB:LEDWP_ADDR_LSB];
         end
      end
   end

   // display memory; the byte is stored whole, bit 7 being the decimal point
   ledwp_ram uRam (
      .clk(clk),
      .wrEn(ramWrite),
      .wrAddr(ramWrAddr),
      .wrData(wrData),
      .rdAddr(ramRdAddr),
      .rdData(ramRdData)
   );

   // blanked scan data while shut down, so no segment lights in low power
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         scanData_reg <= '0;
      end
      else
      begin
         scanData_reg <= ctrlPower ? ramRdData : '0;
      end
   end

   // outputs
   assign scanData = scanData_reg;
   assign decimalPointOut = scanData_reg[LEDWP_DP_BIT];
   assign hexOrBcdSelect = ctrlHex;
   assign noDecode = ctrlNoDec;
   assign powerOn = ctrlPower;
   assign bankSelA = effBank;
   assign oscHalt = !ctrlPower;
   assign displayBlank = !ctrlPower;
   assign seqActive = seqActive_reg;
   assign digitAddr = digitAddr_reg;

   // checks
   sequence ctrlWrSeq;
      ctrlWrite;
   endsequence

   a_wr_single_pulse: assert property (@(posedge clk) disable iff (!rstn)
      wrPulse |=> !wrPulse) else $error("write pulse longer than one cycle");
   a_ctrl_load: assert property (@(posedge clk) disable iff (!rstn)
      ctrlWrSeq |=> ctrl_reg == $past(wrData)) else $error("control word not loaded");
   a_ram_keeps_ctrl: assert property (@(posedge clk) disable iff (!rstn)
      ramWrite |=> $stable(ctrl_reg)) else $error("ram write changed control word");
   a_hex_select: assert property (@(posedge clk) disable iff (!rstn)
      ctrlWrSeq |=> hexOrBcdSelect == $past(wrData[LEDWP_CODE_SEL_BIT]))
      else $error("hex select wrong");
   a_no_decode: assert property (@(posedge clk) disable iff (!rstn)
      ctrlWrSeq |=> noDecode == $past(wrData[LEDWP_DECODE_EN_BIT]) && (!noDecode || bankSelA))
      else $error("decode mode wrong");
   a_seq_start: assert property (@(posedge clk) disable iff (!rstn)
      ctrlWrSeq ##0 wrData[LEDWP_UPDATE_TYPE_BIT] |=> seqActive && seqIndex_reg == 3'h0)
      else $error("sequential fill not started");
   a_shutdown_blank: assert property (@(posedge clk) disable iff (!rstn)
      !powerOn ##1 !powerOn |-> scanData == 8'h00 && oscHalt)
      else $error("display not blanked in shutdown");
   a_single_addr: assert property (@(posedge clk) disable iff (!rstn)
      ctrlWrSeq ##0 !wrData[LEDWP_UPDATE_TYPE_BIT] |=> !seqActive
      && digitAddr == $past(wrData[2:0])) else $error("digit address not latched");
   a_bank_decode: assert property (@(posedge clk) disable iff (!rstn)
      !noDecode |-> bankSelA == ctrl_reg[LEDWP_BANK_SEL_BIT]) else $error("bank select wrong");
   a_seq_end: assert property (@(posedge clk) disable iff (!rstn)
      ramWrite && seqActive && seqIndex_reg == 3'h7 |=> !seqActive)
      else $error("sequential fill not ended after eight");
   a_seq_step: assert property (@(posedge clk) disable iff (!rstn)
      ramWrite && seqActive |=> seqIndex_reg == $past(seqIndex_reg) + 3'h1)
      else $error("sequential index not advanced");
   a_single_target: assert property (@(posedge clk) disable iff (!rstn)
      ramWrite && !seqActive |-> ramWrAddr[2:0] == digitAddr)
      else $error("single write to wrong digit");
   // a fill may only run while the stored word still announces sequential data
   a_seq_needs_word: assert property (@(posedge clk) disable iff (!rstn)
      seqActive |-> ctrlSeq) else $error("sequential fill without announcing word");
endmodule : ledwp_top
